// ### src/secl_map.vh
// Register map, serial frame codes, image offsets and timing for the EEPROM loader.
`ifndef SECL_MAP_VH
`define SECL_MAP_VH

// ----------------------------------------------------------------------------
// Register word indices (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define SECL_REG_CMD        4'h0
`define SECL_REG_DATA       4'h1
`define SECL_REG_STA_LO     4'h2
`define SECL_REG_STA_HI     4'h3
`define SECL_REG_WAKE       4'h4
`define SECL_REG_PME        4'h5
`define SECL_REG_DESC_STAT  4'h6
`define SECL_REG_DESC_SEL   4'h7
`define SECL_REG_RAM_ADDR   4'h8
`define SECL_REG_RAM_DATA   4'h9

// ----------------------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------------------
`define SECL_CMD_BUSY_BIT   31
`define SECL_CMD_OP_HI      30
`define SECL_CMD_OP_LO      28
`define SECL_CMD_TO_BIT     10
`define SECL_CMD_LOAD_BIT   9

// Host commands held in the command field.
`define SECL_OP_READ        3'h0
`define SECL_OP_ERASE_WRITE_DISABLE_COMMAND        3'h1
`define SECL_OP_ERASE_WRITE_ENABLE_COMMAND        3'h2
`define SECL_OP_WRITE       3'h3
`define SECL_OP_WRITE_ALL_COMMAND        3'h4
`define SECL_OP_ERASE       3'h5
`define SECL_OP_ERASE_ALL_COMMAND        3'h6
`define SECL_OP_RELOAD      3'h7

// ----------------------------------------------------------------------------
// Serial frame coding
// ----------------------------------------------------------------------------
`define SECL_LEN_SHORT      5'h0a
`define SECL_LEN_LONG       5'h12
`define SECL_OPC_READ       2'h2
`define SECL_OPC_WRITE      2'h1
`define SECL_OPC_ERASE      2'h3
`define SECL_OPC_SPECIAL    2'h0
`define SECL_SUB_ERASE_WRITE_DISABLE_COMMAND       2'h0
`define SECL_SUB_WRITE_ALL_COMMAND       2'h1
`define SECL_SUB_ERASE_ALL_COMMAND       2'h2
`define SECL_SUB_ERASE_WRITE_ENABLE_COMMAND       2'h3
`define SECL_POLL_SETTLE    19'h00004

// ----------------------------------------------------------------------------
// Image layout
// ----------------------------------------------------------------------------
`define SECL_IMG_MARK_ADDR  7'h00
`define SECL_IMG_MARK       8'ha5
`define SECL_IMG_MAC_FIRST  7'h01
`define SECL_IMG_MAC_LAST   7'h06
`define SECL_IMG_WAKE_LO    7'h07
`define SECL_IMG_WAKE_HI    7'h08
`define SECL_IMG_PME_LO     7'h09
`define SECL_IMG_PME_HI     7'h0a
`define SECL_IMG_POL_LO     7'h0e
`define SECL_IMG_POL_HI     7'h0f
`define SECL_IMG_DESC_FIRST 7'h25
`define SECL_IMG_DESC_LAST  7'h3c
`define SECL_IMG_LOAD_LAST  7'h3c
`define SECL_DESC_COUNT     12
`define SECL_DESC_FIXED_1ST 6
`define SECL_DESC_STR_LAST  4
`define SECL_DESC_FIX_LEN   8'h12

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SECL_CLK_KHZ        10000
`define SECL_TIMEOUT_MS     30
`define SECL_TIMEOUT_CYCLES 19'h493e0
`define SECL_SK_LAST        3'h7
`define SECL_SK_RISE        3'h3

`endif

// ### src/secl_desc_ram.v
// Descriptor RAM holding the loaded image, with registered read data.
module secl_desc_ram (
  input  wire       sys_clk,
  input  wire       wr_en,
  input  wire [8:0] wr_addr,
  input  wire [7:0] wr_data,
  input  wire [8:0] rd_addr,
  output reg  [7:0] rd_data
);

  reg [7:0] mem [0:511];

  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // secl_desc_ram

// ### src/secl_top.v
// Serial EEPROM command engine, image loader and register slave.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`include "secl_map.vh"

module secl_top #(
  parameter [18:0] TIMEOUT_CYCLES = `SECL_TIMEOUT_CYCLES
) (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        soft_reset_req,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg         ee_cs,
  output reg         serial_memory_clock,
  output reg         ee_di,
  input  wire        ee_do,
  output reg         usb_disconnect
);

  // --------------------------------------------------------------------------
  // State and storage
  // --------------------------------------------------------------------------
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_FRAME = 4'b0010;
  localparam [3:0] ST_GAP   = 4'b0100;
  localparam [3:0] ST_POLL  = 4'b1000;

  reg  [3:0]  state;
  reg  [2:0]  div_cnt;
  reg  [4:0]  bit_cnt;
  reg  [4:0]  frame_len;
  reg  [17:0] tx;
  reg  [7:0]  rx;
  reg         needs_poll;
  reg  [18:0] to_cnt;
  reg         do_meta;
  reg         do_sync;
  reg         command_busy_flag;
  reg         command_timeout_flag;
  reg         data_loaded;
  reg  [2:0]  op;
  reg  [8:0]  eeprom_word_address_field;
  reg  [7:0]  eeprom_data_register;
  reg         loading;
  reg         load_req;
  reg  [6:0]  load_addr;
  reg  [47:0] station_address;
  reg  [11:0] pin_wakeup_enable_field;
  reg  [11:0] pin_wakeup_polarity_field;
  reg  [15:0] power_event_flags;
  reg  [95:0] desc_len;
  reg  [95:0] desc_off;
  reg  [3:0]  desc_sel;
  reg  [8:0]  ram_rd_addr;
  reg  [31:0] rd_mux;
  wire [7:0]  ram_rd_data;
  wire [11:0] desc_present;
  wire [11:0] desc_error;
  wire        busy_any = command_busy_flag | loading | load_req;
  wire        bus_take = avs_write & ~avs_waitrequest;
  wire        ram_we   = loading && (state == ST_GAP) && (div_cnt == `SECL_SK_LAST);
  wire [7:0]  sel_len  = desc_len[{desc_sel, 3'h0} +: 8];
  wire [7:0]  sel_off  = desc_off[{desc_sel, 3'h0} +: 8];
  wire        lang_ok  = data_loaded & (|desc_present[`SECL_DESC_STR_LAST:0]);

  // --------------------------------------------------------------------------
  // Frame builder
  // --------------------------------------------------------------------------
  // The serial address field is seven bits wide so that the frame lengths
  // come out at exactly ten and eighteen clocks.
  function [17:0] frame_word;
    input [2:0] cmd;
    input [6:0] adr;
    input [7:0] dat;
    begin
      case (cmd)
        `SECL_OP_WRITE: frame_word = {1'b1, `SECL_OPC_WRITE, adr, dat};
        `SECL_OP_WRITE_ALL_COMMAND:  frame_word = {1'b1, `SECL_OPC_SPECIAL, `SECL_SUB_WRITE_ALL_COMMAND, 5'h00, dat};
        `SECL_OP_ERASE: frame_word = {1'b1, `SECL_OPC_ERASE, adr, 8'h00};
        `SECL_OP_ERASE_ALL_COMMAND:  frame_word = {1'b1, `SECL_OPC_SPECIAL, `SECL_SUB_ERASE_ALL_COMMAND, 5'h00, 8'h00};
        `SECL_OP_ERASE_WRITE_ENABLE_COMMAND:  frame_word = {1'b1, `SECL_OPC_SPECIAL, `SECL_SUB_ERASE_WRITE_ENABLE_COMMAND, 5'h00, 8'h00};
        `SECL_OP_ERASE_WRITE_DISABLE_COMMAND:  frame_word = {1'b1, `SECL_OPC_SPECIAL, `SECL_SUB_ERASE_WRITE_DISABLE_COMMAND, 5'h00, 8'h00};
        default:        frame_word = {1'b1, `SECL_OPC_READ, adr, 8'h00};
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Descriptor checks
  // --------------------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < `SECL_DESC_COUNT; k = k + 1) begin : g_desc
      wire [7:0] len = desc_len[8*k +: 8];
      wire       fix = (k >= `SECL_DESC_FIXED_1ST);
      assign desc_error[k]   = fix && (len != 8'h00) && (len != `SECL_DESC_FIX_LEN);
      assign desc_present[k] = (len != 8'h00) && !desc_error[k];
    end
  endgenerate

  secl_desc_ram u_ram (
    .sys_clk (sys_clk),
    .wr_en   (ram_we),
    .wr_addr ({2'b00, load_addr}),
    .wr_data (rx),
    .rd_addr (ram_rd_addr),
    .rd_data (ram_rd_data)
  );

  // --------------------------------------------------------------------------
  // Register read mux
  // --------------------------------------------------------------------------
  always @* begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `SECL_REG_CMD: begin
        rd_mux[`SECL_CMD_BUSY_BIT]               = busy_any;
        rd_mux[`SECL_CMD_OP_HI:`SECL_CMD_OP_LO]  = op;
        rd_mux[`SECL_CMD_TO_BIT]                 = command_timeout_flag;
        rd_mux[`SECL_CMD_LOAD_BIT]               = data_loaded;
        rd_mux[8:0]                              = eeprom_word_address_field;
      end
      `SECL_REG_DATA:      rd_mux[7:0] = eeprom_data_register;
      `SECL_REG_STA_LO:    rd_mux = station_address[31:0];
      `SECL_REG_STA_HI:    rd_mux[15:0] = station_address[47:32];
      `SECL_REG_WAKE:      rd_mux = {4'h0, pin_wakeup_polarity_field,
                                     4'h0, pin_wakeup_enable_field};
      `SECL_REG_PME:       rd_mux[16:0] = {lang_ok, power_event_flags};
      `SECL_REG_DESC_STAT: rd_mux = {4'h0, desc_error, 4'h0, desc_present};
      `SECL_REG_DESC_SEL: begin
        rd_mux[31:28] = desc_sel;
        rd_mux[23:16] = desc_present[desc_sel] ? sel_len : 8'h00;
        rd_mux[8:0]   = desc_present[desc_sel] ? {sel_off, 1'b0} : 9'h000;
      end
      `SECL_REG_RAM_ADDR:  rd_mux[8:0] = ram_rd_addr;
      `SECL_REG_RAM_DATA:  rd_mux[7:0] = ram_rd_data;
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // Bus slave, command engine and loader
  // --------------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      avs_readdata              <= 32'h0000_0000;
      avs_waitrequest           <= 1'b1;
      ee_cs                     <= 1'b0;
      serial_memory_clock       <= 1'b0;
      ee_di                     <= 1'b0;
      usb_disconnect            <= 1'b1;
      state                     <= ST_IDLE;
      div_cnt                   <= 3'h0;
      bit_cnt                   <= 5'h00;
      frame_len                 <= 5'h00;
      tx                        <= 18'h00000;
      rx                        <= 8'h00;
      needs_poll                <= 1'b0;
      to_cnt                    <= 19'h00000;
      do_meta                   <= 1'b0;
      do_sync                   <= 1'b0;
      command_busy_flag         <= 1'b0;
      command_timeout_flag      <= 1'b0;
      data_loaded               <= 1'b0;
      op                        <= `SECL_OP_READ;
      eeprom_word_address_field <= 9'h000;
      eeprom_data_register      <= 8'h00;
      loading                   <= 1'b0;
      load_req                  <= 1'b1;
      load_addr                 <= 7'h00;
      station_address           <= 48'h0000_0000_0000;
      pin_wakeup_enable_field   <= 12'h000;
      pin_wakeup_polarity_field <= 12'h000;
      power_event_flags         <= 16'h0000;
      desc_len                  <= 96'h0;
      desc_off                  <= 96'h0;
      desc_sel                  <= 4'h0;
      ram_rd_addr               <= 9'h000;
    end else begin
      do_meta <= ee_do;
      do_sync <= do_meta;

      // One wait cycle on every access; read data is registered meanwhile.
      if ((avs_read | avs_write) & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= rd_mux;
      end else begin
        avs_waitrequest <= 1'b1;
      end

      if (soft_reset_req) begin
        load_req       <= 1'b1;
        usb_disconnect <= 1'b1;
      end

      // Writes to the command or data register while busy are dropped.
      if (bus_take && !busy_any) begin
        case (avs_address)
          `SECL_REG_CMD: begin
            if (avs_byteenable[0]) eeprom_word_address_field[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1]) begin
              eeprom_word_address_field[8] <= avs_writedata[8];
              if (avs_writedata[`SECL_CMD_TO_BIT]) command_timeout_flag <= 1'b0;
            end
            if (avs_byteenable[3]) begin
              op <= avs_writedata[`SECL_CMD_OP_HI:`SECL_CMD_OP_LO];
              if (avs_writedata[`SECL_CMD_BUSY_BIT]) begin
                if (avs_writedata[`SECL_CMD_OP_HI:`SECL_CMD_OP_LO] == `SECL_OP_RELOAD) begin
                  load_req <= 1'b1;
                end else begin
                  command_busy_flag <= 1'b1;
                end
              end
            end
          end
          `SECL_REG_DATA: if (avs_byteenable[0]) eeprom_data_register <= avs_writedata[7:0];
          default: ;
        endcase
      end
      if (bus_take) begin
        if (avs_address == `SECL_REG_DESC_SEL && avs_byteenable[3])
          desc_sel <= avs_writedata[31:28];
        if (avs_address == `SECL_REG_RAM_ADDR && avs_byteenable[0])
          ram_rd_addr <= {avs_byteenable[1] ? avs_writedata[8] : ram_rd_addr[8],
                          avs_writedata[7:0]};
      end

      case (state)
        ST_IDLE: begin
          div_cnt <= 3'h0;
          bit_cnt <= 5'h00;
          if (load_req) begin
            // A reload drops data_loaded and desc_len only, so a failed one leaves the other fields at their earlier values.
            load_req    <= 1'b0;
            loading     <= 1'b1;
            data_loaded <= 1'b0;
            desc_len    <= 96'h0;
            load_addr   <= `SECL_IMG_MARK_ADDR;
            tx          <= frame_word(`SECL_OP_READ, `SECL_IMG_MARK_ADDR, 8'h00);
            frame_len   <= `SECL_LEN_LONG;
            needs_poll  <= 1'b0;
            ee_cs       <= 1'b1;
            ee_di       <= 1'b1;
            state       <= ST_FRAME;
          end else if (command_busy_flag) begin
            tx <= frame_word(op, eeprom_word_address_field[6:0],
                             eeprom_data_register);
            frame_len <= (op == `SECL_OP_READ || op == `SECL_OP_WRITE ||
                          op == `SECL_OP_WRITE_ALL_COMMAND) ? `SECL_LEN_LONG : `SECL_LEN_SHORT;
            needs_poll <= (op == `SECL_OP_WRITE || op == `SECL_OP_WRITE_ALL_COMMAND ||
                           op == `SECL_OP_ERASE || op == `SECL_OP_ERASE_ALL_COMMAND);
            ee_cs <= 1'b1;
            ee_di <= 1'b1;
            state <= ST_FRAME;
          end
        end
        ST_FRAME: begin
          div_cnt <= div_cnt + 3'h1;
          if (div_cnt == `SECL_SK_RISE) serial_memory_clock <= 1'b1;
          if (div_cnt == `SECL_SK_LAST) begin
            serial_memory_clock <= 1'b0;
            rx      <= {rx[6:0], do_sync};
            tx      <= {tx[16:0], 1'b0};
            ee_di   <= tx[16];
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == frame_len - 5'h01) begin
              ee_cs <= 1'b0;
              ee_di <= 1'b0;
              state <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          // Chip select stays low for one full serial clock period.
          div_cnt <= div_cnt + 3'h1;
          if (div_cnt == `SECL_SK_LAST) begin
            bit_cnt <= 5'h00;
            if (loading) begin
              if (load_addr >= `SECL_IMG_MAC_FIRST && load_addr <= `SECL_IMG_MAC_LAST)
                station_address <= {rx, station_address[47:8]};
              case (load_addr)
                `SECL_IMG_WAKE_LO: pin_wakeup_enable_field[7:0]    <= rx;
                `SECL_IMG_WAKE_HI: pin_wakeup_enable_field[11:8]   <= rx[3:0];
                `SECL_IMG_PME_LO:  power_event_flags[7:0]          <= rx;
                `SECL_IMG_PME_HI:  power_event_flags[15:8]         <= rx;
                `SECL_IMG_POL_LO:  pin_wakeup_polarity_field[7:0]  <= rx;
                `SECL_IMG_POL_HI:  pin_wakeup_polarity_field[11:8] <= rx[3:0];
                default: ;
              endcase
              if (load_addr >= `SECL_IMG_DESC_FIRST && load_addr <= `SECL_IMG_DESC_LAST) begin
                if (load_addr[0]) desc_len <= {rx, desc_len[95:8]};
                else desc_off <= {rx, desc_off[95:8]};
              end
              if (load_addr == `SECL_IMG_MARK_ADDR && rx != `SECL_IMG_MARK) begin
                loading        <= 1'b0;
                usb_disconnect <= 1'b0;
                state          <= ST_IDLE;
              end else if (load_addr == `SECL_IMG_LOAD_LAST) begin
                loading        <= 1'b0;
                data_loaded    <= 1'b1;
                usb_disconnect <= 1'b0;
                state          <= ST_IDLE;
              end else begin
                load_addr <= load_addr + 7'h01;
                tx        <= frame_word(`SECL_OP_READ, load_addr + 7'h01, 8'h00);
                ee_cs     <= 1'b1;
                ee_di     <= 1'b1;
                state     <= ST_FRAME;
              end
            end else if (needs_poll) begin
              to_cnt <= 19'h00000;
              ee_cs  <= 1'b1;
              state  <= ST_POLL;
            end else begin
              if (op == `SECL_OP_READ) eeprom_data_register <= rx;
              command_busy_flag <= 1'b0;
              state             <= ST_IDLE;
            end
          end
        end
        ST_POLL: begin
          // The memory holds its data line low while programming, high when done.
          to_cnt <= to_cnt + 19'h00001;
          if (to_cnt >= `SECL_POLL_SETTLE && do_sync) begin
            ee_cs             <= 1'b0;
            command_busy_flag <= 1'b0;
            state             <= ST_IDLE;
          end else if (to_cnt == TIMEOUT_CYCLES - 19'h00001) begin
            command_timeout_flag <= 1'b1;
            ee_cs                <= 1'b0;
            command_busy_flag    <= 1'b0;
            state                <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // secl_top

// ### tb/secl_sva.sv
// Port assertions for the serial EEPROM loader.
module secl_sva #(
  parameter [18:0] TIMEOUT_CYCLES = 19'h493e0
) (
  input wire        sys_clk,
  input wire        sys_rst,
  input wire        soft_reset_req,
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        ee_cs,
  input wire        serial_memory_clock,
  input wire        ee_di,
  input wire        ee_do,
  input wire        usb_disconnect
);
  timeunit 1ns;
  timeprecision 100ps;
  // Poll phases raise chip select with no clocks, so a frame may close with zero rises.
  logic        sk_q;
  logic [4:0]  sk_cnt;
  logic [19:0] cs_run;
  always @(posedge sys_clk) begin
    sk_q <= serial_memory_clock;
    sk_cnt <= (sys_rst || !ee_cs) ? 5'h00 : sk_cnt + {4'h0, serial_memory_clock & ~sk_q};
    cs_run <= (sys_rst || !ee_cs) ? 20'h00000 : cs_run + 20'h00001;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  a_wait_pulse: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
  a_frame_len: assert property (
    $fell(ee_cs) |-> sk_cnt inside {5'h00, 5'h0a, 5'h12}) else $error("bad clock count");
  a_sk_idle: assert property (
    !ee_cs |-> !serial_memory_clock) else $error("clock outside frame");
  a_start_bit: assert property (
    $rose(serial_memory_clock) && sk_cnt == 5'h00 |-> ee_di) else $error("no start bit");
  a_sk_high: assert property (
    $rose(serial_memory_clock) |-> serial_memory_clock[*4] ##1 !serial_memory_clock)
    else $error("clock high phase wrong");
  a_usb_hold: assert property (
    $fell(sys_rst) |-> usb_disconnect ##1 usb_disconnect) else $error("link not held off");
  a_poll_bound: assert property (
    cs_run <= TIMEOUT_CYCLES + 20'h000a0) else $error("poll not abandoned");
endmodule // secl_sva

bind secl_top secl_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_sva (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .soft_reset_req(soft_reset_req),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ee_cs(ee_cs),
  .serial_memory_clock(serial_memory_clock), .ee_di(ee_di), .ee_do(ee_do),
  .usb_disconnect(usb_disconnect));

// ### tb/secl_mem_model.sv
// Behavioural three-wire serial EEPROM with ready polling.
module secl_mem_model (
  input wire   ee_cs,
  input wire   sk,
  input wire   di,
  output logic dout
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [0:127];
  logic [17:0] sh;
  logic [1:0]  opc;
  logic [6:0]  adr;
  logic        en = 1'b0;
  logic        stuck = 1'b0;
  logic        poll = 1'b0;
  int          n = 0;
  int          prog_ns = 500;
  realtime     rdy = 0;
  initial dout = 1'b0;
  always @(posedge sk) begin
    sh = {sh[16:0], di};
    n++;
    if (n == 10) {opc, adr} = sh[8:0];
    if (n > 10 && opc == 2'b10) dout = mem[adr][18 - n];
  end
  always @(posedge ee_cs) begin
    n = 0;
    if (poll) begin
      dout = 1'b0;
      while (ee_cs && (stuck || $realtime < rdy)) #100;
      if (ee_cs) dout = 1'b1;
    end
  end
  // A released line shows the inverse of its last level so stale data cannot pass.
  always @(negedge ee_cs) begin
    dout = ~dout;
    if (n == 0) poll = 1'b0;
    else if (opc == 2'b00 && adr[6:5] == 2'b11) en = 1'b1;
    else if (opc == 2'b00 && adr[6:5] == 2'b00) en = 1'b0;
    else if (opc != 2'b10) begin
      poll = 1'b1;
      rdy = $realtime + prog_ns;
      for (int i = 0; i < 128; i++)
        if (en && (opc == 2'b00 || i == adr))
          mem[i] = (opc == 2'b01 || (opc == 2'b00 && adr[5])) ? sh[7:0] : 8'hff;
    end
  end
endmodule // secl_mem_model

// ### tb/serial_eeprom_command_loader_tb.sv
// Self-checking bench for the serial EEPROM loader.
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module serial_eeprom_command_loader_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, soft_reset_req = 1'b0, avs_read = 1'b0;
  logic        avs_write = 1'b0, avs_waitrequest, ee_cs, sk, ee_di, ee_do, usb_disconnect;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [7:0]  r [0:127];
  logic [7:0]  lf = 8'h5e;
  int          fails = 0, check_count = 0;
  always #50 sys_clk = ~sys_clk;
  secl_top #(.TIMEOUT_CYCLES(19'h000c8)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .soft_reset_req(soft_reset_req), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ee_cs(ee_cs),
    .serial_memory_clock(sk), .ee_di(ee_di), .ee_do(ee_do), .usb_disconnect(usb_disconnect));
  secl_mem_model mdl (.ee_cs(ee_cs), .sk(sk), .di(ee_di), .dout(ee_do));
  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    avs_byteenable <= be;
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [3:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffffffff);
    bus(1'b0, a, 32'h0, 4'hf);
    `CHK(nm, e, q & m)
  endtask
  task automatic idle();
    q = 32'h80000000;
    for (int i = 0; i < 3000 && q[31] !== 1'b0; i++) begin
      repeat (8) @(posedge sys_clk);
      bus(1'b0, 4'h0, 32'h0, 4'hf);
    end
    `CHK("busy_clear", 1'b0, q[31])
  endtask
  task automatic cmd(input logic [2:0] op, input logic [6:0] a);
    bus(1'b1, 4'h0, {1'b1, op, 21'h0, a}, 4'hf);
    idle();
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk);
    fails++;
    final_report();
  end
  initial begin
    logic [7:0] d;
    logic [6:0] a;
    foreach (r[i]) r[i] = (i < 11 || i == 14 || i == 15) ? rnd() : 8'h00;
    r[0] = 8'ha5;
    {r[8'h2f], r[8'h31], r[8'h32], r[8'h33]} = 32'h05122010;
    foreach (r[i]) mdl.mem[i] = r[i];
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    `CHK("disconnect", 1'b1, usb_disconnect)
    idle();
    `CHK("disconnect", 1'b0, usb_disconnect)
    chk("loaded", 4'h0, 32'h200, 32'h200);
    chk("station_lo", 4'h2, {r[4], r[3], r[2], r[1]});
    chk("station_hi", 4'h3, {16'h0, r[6], r[5]});
    chk("wake", 4'h4, {4'h0, r[15][3:0], r[14], 4'h0, r[8][3:0], r[7]});
    chk("power_event", 4'h5, {16'h0, r[10], r[9]});
    chk("desc_status", 4'h6, 32'h00800060);
    bus(1'b1, 4'h7, 32'h60000000, 4'hf);
    chk("desc_select", 4'h7, 32'h60120040);
    bus(1'b1, 4'h8, 32'h7, 4'hf);
    chk("ram_addr", 4'h8, 32'h7);
    chk("ram_data", 4'h9, {24'h0, r[7]});
    chk("unmapped", 4'hc, 32'h0);
    $display("test load done");
    cmd(3'h2, 7'h00);
    for (int k = 0; k < 4; k++) begin
      d = rnd();
      a = d[6:0];
      d = rnd();
      mdl.prog_ns = k * 2500;
      bus(1'b1, 4'h1, {24'h0, d}, 4'hf);
      cmd(3'h3, a);
      cmd(3'h0, a);
      chk("read", 4'h1, {24'h0, d}, 32'hff);
      cmd(3'h5, a);
      cmd(3'h0, a);
      chk("erase", 4'h1, 32'hff, 32'hff);
    end
    bus(1'b1, 4'h1, {24'h0, d}, 4'hf);
    cmd(3'h4, 7'h00);
    cmd(3'h0, a);
    chk("write_all", 4'h1, {24'h0, d}, 32'hff);
    cmd(3'h7, 7'h00);
    chk("reload_fail", 4'h0, (d == 8'ha5) ? 32'h200 : 32'h0, 32'h200);
    bus(1'b1, 4'h1, 32'ha5, 4'hf);
    cmd(3'h3, 7'h00);
    cmd(3'h7, 7'h00);
    chk("reload_ok", 4'h0, 32'h200, 32'h200);
    chk("station_lo", 4'h2, {d, d, d, d});
    chk("language", 4'h5, (d != 8'h00) ? 32'h10000 : 32'h0, 32'h10000);
    cmd(3'h6, 7'h00);
    cmd(3'h1, 7'h00);
    cmd(3'h0, 7'h7f);
    chk("erase_all", 4'h1, 32'hff, 32'hff);
    $display("test commands done");
    cmd(3'h2, 7'h00);
    mdl.stuck = 1'b1;
    cmd(3'h3, 7'h01);
    chk("timeout", 4'h0, 32'h400, 32'h400);
    mdl.stuck = 1'b0;
    bus(1'b1, 4'h0, 32'h400, 4'h2);
    chk("timeout_clear", 4'h0, 32'h0, 32'h400);
    $display("test timeout done");
    soft_reset_req <= 1'b1;
    @(posedge sys_clk);
    soft_reset_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK("disconnect", 1'b1, usb_disconnect)
    idle();
    chk("soft_reload", 4'h0, 32'h0, 32'h200);
    $display("test soft reset done");
    final_report();
  end
endmodule // serial_eeprom_command_loader_tb
